// *** rtl/dapd_datapath.sv ***
// arithmetic and pointer datapath: general registers, pointers, overflow flag
// assumes a decoder supplies one instruction per cycle and a memory path
// that uses o_mem_addr in the same cycle
// Behaviour
// - every instruction is one 32-bit word selecting one operation class
// - pointer updated after its access, visible to next instruction
// - no modify-mode pointer update without a memory access through it
// - plain mode keeps pointer, increment adds one, decrement subtracts one
// - index-add mode adds the same-numbered step register
// - modulo mode wraps lower part by size plus one, upper part kept
// - bit-reverse addresses reversed pointer, then adds step
// - overflow flag is set on overflow and never cleared by operations
// - signed high-half multiply-add and multiply-subtract into 40 bits
// - signed high times unsigned low multiply-add
// - unsigned low times unsigned low multiply-add
// - accumulator shifted right 1 or 16 first; only 1-bit form flags
// - add and subtract, register or immediate forms, update flag
// - shifts take amount from a low half or immediate
// - and, or, xor in register and immediate forms
// - less-than writes one or zero
// - clear loads zero into all 40 bits
// - increment, decrement, magnitude, invert, negate, copy
// - saturate clamps to the signed 32-bit range
// - round saturates, else adds 0x8000 and clears low 16 bits
// - exponent returns redundant sign bit count
// - register forms may pair with a store or with a load whose data is dropped, immediate forms may not
// - registers split into low half, high half and guard byte
// - arithmetic right fills sign, logical right fills zero
// - exponent examines bits 31-0, result bits 39-5 are zero
`timescale 1ns/1ps
`default_nettype none
module dapd_datapath #(
  parameter int PTR_W = 16
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_valid,
  input  wire logic [31:0]          i_instr,
  input  wire logic [15:0]          i_load_data,
  input  wire logic                 i_set_step,
  input  wire logic                 i_set_size,
  input  wire logic [2:0]           i_set_index,
  input  wire logic [PTR_W-1:0]     i_set_value,
  output logic                      o_mem_access,
  output logic                      o_mem_write,
  output logic      [PTR_W-1:0]     o_mem_addr,
  output logic      [15:0]          o_store_data,
  output logic                      o_result_excess_flag,
  output logic      [39:0]          o_result,
  output logic                      o_illegal
);
  initial if (PTR_W != 16) $error("dapd_datapath: pointer width must be 16");

  typedef struct packed {
    logic [7:0][39:0]          general_register;
    logic [7:0][PTR_W-1:0]     data_pointer;
    logic [7:0][PTR_W-1:0]     pointer_step;
    logic [PTR_W-1:0]          x_modulo_size;
    logic [PTR_W-1:0]          y_modulo_size;
    logic                      result_excess_flag;
    logic [39:0]               result;
    logic                      illegal;
  } dapd_state_type;

  dapd_state_type state_reg;
  dapd_state_type state_next;
  logic [1:0]     rst_sync_reg;
  logic           rst_n;

  // reset released through two flops; kept out of the struct, own reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= dapd_pkg::SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // instruction fields
  logic [3:0]  op_class;
  logic [4:0]  op;
  logic [2:0]  ra, rb, rd, pidx, pmode;
  logic        ls_en;
  logic [6:0]  imm7;
  logic [12:0] imm13;
  assign op_class = i_instr[dapd_pkg::CLASS_LSB +: 4];
  assign op       = i_instr[dapd_pkg::OP_LSB +: 5];
  assign ra       = i_instr[dapd_pkg::RA_LSB +: 3];
  assign rb       = i_instr[dapd_pkg::RB_LSB +: 3];
  assign rd       = i_instr[dapd_pkg::RD_LSB +: 3];
  assign ls_en    = i_instr[dapd_pkg::LS_BIT];
  assign pidx     = i_instr[dapd_pkg::PTR_LSB +: 3];
  assign pmode    = i_instr[dapd_pkg::MOD_LSB +: 3];
  assign imm7     = i_instr[dapd_pkg::IMM_LSB +: 7];
  assign imm13    = i_instr[dapd_pkg::IMM_LSB +: 13];

  logic [39:0] opa, opb, immx;
  logic [15:0] a_hi, a_lo, b_hi, b_lo;
  assign opa  = state_reg.general_register[ra];
  assign opb  = state_reg.general_register[rb];
  assign a_hi = opa[31:16];
  assign a_lo = opa[15:0];
  assign b_hi = opb[31:16];
  assign b_lo = opb[15:0];
  assign immx = {{27{imm13[12]}}, imm13};

  // pointer unit for the selected pointer
  logic [PTR_W-1:0] ptr_next, ptr_addr, ptr_size;
  assign ptr_size = pidx[2] ? state_reg.y_modulo_size : state_reg.x_modulo_size;
  dapd_ptr_unit #(.W(PTR_W)) u_ptr (
    .i_ptr  (state_reg.data_pointer[pidx]),
    .i_step (state_reg.pointer_step[pidx]),
    .i_size (ptr_size),
    .i_imm  (PTR_W'(imm7)),
    .i_mode (pmode),
    .o_next (ptr_next),
    .o_addr (ptr_addr)
  );

  logic [39:0] norm_cnt;
  dapd_norm_count u_norm (
    .i_val   (opa),
    .o_count (norm_cnt)
  );

  // arithmetic core
  logic signed [41:0] wide;
  logic signed [41:0] acc_s;
  logic signed [41:0] prod;
  logic               do_write;
  logic               flag_op;
  logic [39:0]        res;
  logic [5:0]         shamt;
  logic               mem_ok;

  always_comb begin
    wide     = 42'sd0;
    acc_s    = $signed({{2{opa[39]}}, opa});
    prod     = 42'sd0;
    do_write = 1'b0;
    flag_op  = 1'b0;
    res      = dapd_pkg::ZERO40;
    shamt    = 6'h00;
    mem_ok   = 1'b0;
    case (op_class)
      dapd_pkg::CL_TRI: begin
        mem_ok   = 1'b1;
        do_write = 1'b1;
        flag_op  = 1'b1;
        // accumulator is the destination register
        acc_s = $signed({{2{state_reg.general_register[rd][39]}},
                         state_reg.general_register[rd]});
        prod  = 42'($signed(a_hi) * $signed(b_hi));
        case (op)
          dapd_pkg::T_MADD:  wide = acc_s + prod;
          dapd_pkg::T_MSUB:  wide = acc_s - prod;
          dapd_pkg::T_SUMA:  wide = acc_s + 42'($signed(a_hi) * $signed({1'b0, b_lo}));
          dapd_pkg::T_UUMA:  wide = acc_s + $signed({10'h0, 32'(a_lo) * 32'(b_lo)});
          dapd_pkg::T_SH1MA: wide = (acc_s >>> 1) + prod;
          dapd_pkg::T_SH16M: begin
            wide    = (acc_s >>> 16) + prod;
            flag_op = 1'b0;
          end
          default: do_write = 1'b0;
        endcase
        res = wide[39:0];
      end
      dapd_pkg::CL_TWO_OPERAND_CLASS, dapd_pkg::CL_DYADI: begin
        mem_ok   = (op_class == dapd_pkg::CL_TWO_OPERAND_CLASS);
        do_write = 1'b1;
        if (op_class == dapd_pkg::CL_DYADI) begin
          acc_s = $signed({{2{immx[39]}}, immx});
          shamt = imm13[5:0];
        end else begin
          acc_s = $signed({{2{opb[39]}}, opb});
          shamt = (b_lo > 16'd40) ? 6'd40 : b_lo[5:0];
        end
        case (op)
          dapd_pkg::D_MUL: res = 40'($signed(a_hi) * $signed(b_hi));
          dapd_pkg::D_ADD: begin
            wide = $signed({{2{opa[39]}}, opa}) + acc_s;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::D_SUB: begin
            wide = $signed({{2{opa[39]}}, opa}) - acc_s;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::D_SRA: res = 40'($signed(opa) >>> shamt);
          dapd_pkg::D_SRL: res = opa >> shamt;
          dapd_pkg::D_SLL: res = opa << shamt;
          dapd_pkg::D_AND: res = opa & acc_s[39:0];
          dapd_pkg::D_OR:  res = opa | acc_s[39:0];
          dapd_pkg::D_XOR: res = opa ^ acc_s[39:0];
          dapd_pkg::D_LT:  res = ($signed(opa) < $signed(acc_s[39:0])) ?
                                 dapd_pkg::LT_TRUE : dapd_pkg::ZERO40;
          default: do_write = 1'b0;
        endcase
      end
      dapd_pkg::CL_ONE_OPERAND_CLASS: begin
        mem_ok   = 1'b1;
        do_write = 1'b1;
        acc_s    = $signed({{2{opa[39]}}, opa});
        case (op)
          dapd_pkg::M_CLR: res = dapd_pkg::ZERO40;
          dapd_pkg::M_INC: begin
            wide = acc_s + 42'sd1;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::M_DEC: begin
            wide = acc_s - 42'sd1;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::M_ABS: begin
            wide = opa[39] ? -acc_s : acc_s;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::M_NOT: res = ~opa;
          dapd_pkg::M_NEG: begin
            wide = -acc_s;
            res = wide[39:0];
            flag_op = 1'b1;
          end
          dapd_pkg::M_CLIP: begin
            flag_op = 1'b1;
            if ($signed(opa) > $signed(dapd_pkg::SAT_POS)) res = dapd_pkg::SAT_POS;
            else if ($signed(opa) < $signed(dapd_pkg::SAT_NEG)) res = dapd_pkg::SAT_NEG;
            else res = opa;
            wide = $signed({{2{res[39]}}, res});
          end
          dapd_pkg::M_RND: begin
            flag_op = 1'b1;
            if ($signed(opa) > $signed(dapd_pkg::RND_POS)) res = dapd_pkg::RND_POS;
            else if ($signed(opa) < $signed(dapd_pkg::SAT_NEG)) res = dapd_pkg::SAT_NEG;
            else res = (opa + dapd_pkg::RND_ADD) & dapd_pkg::RND_MASK;
            wide = $signed({{2{res[39]}}, res});
          end
          dapd_pkg::M_EXP: res = norm_cnt;
          dapd_pkg::M_MOV: res = opa;
          default: do_write = 1'b0;
        endcase
      end
      dapd_pkg::CL_LDST: mem_ok = 1'b1;
      default: mem_ok = 1'b0;
    endcase
  end

  // overflow: result outside signed 40-bit range
  logic ovf;
  assign ovf = flag_op && (wide[41:39] != {3{wide[39]}});

  logic access;
  assign access = i_valid && ls_en && mem_ok;

  always_comb begin
    state_next          = state_reg;
    state_next.illegal  = i_valid && ls_en && !mem_ok;
    if (i_valid && do_write) begin
      state_next.general_register[rd] = res;
      state_next.result               = res;
    end
    // load lands only for the load/store class, in the low half
    if (access && !i_instr[dapd_pkg::RB_LSB + 2] && op_class == dapd_pkg::CL_LDST)
      state_next.general_register[rd][15:0] = i_load_data;
    if (i_valid && ovf)
      state_next.result_excess_flag = 1'b1;
    if (access)
      state_next.data_pointer[pidx] = ptr_next;
    if (i_set_step)
      state_next.pointer_step[i_set_index] = i_set_value;
    if (i_set_size && !i_set_index[2])
      state_next.x_modulo_size = i_set_value;
    if (i_set_size && i_set_index[2])
      state_next.y_modulo_size = i_set_value;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.general_register   <= '0;
      state_reg.data_pointer       <= '0;
      state_reg.pointer_step       <= '0;
      state_reg.x_modulo_size      <= dapd_pkg::SIZE_RESET;
      state_reg.y_modulo_size      <= dapd_pkg::SIZE_RESET;
      state_reg.result_excess_flag <= 1'b0;
      state_reg.result             <= dapd_pkg::ZERO40;
      state_reg.illegal            <= 1'b0;
    end else begin
      state_reg.general_register   <= state_next.general_register;
      state_reg.data_pointer       <= state_next.data_pointer;
      state_reg.pointer_step       <= state_next.pointer_step;
      state_reg.x_modulo_size      <= state_next.x_modulo_size;
      state_reg.y_modulo_size      <= state_next.y_modulo_size;
      state_reg.result_excess_flag <= state_next.result_excess_flag;
      state_reg.result             <= state_next.result;
      state_reg.illegal            <= state_next.illegal;
    end
  end

  assign o_mem_access         = access;
  assign o_mem_write          = access && i_instr[dapd_pkg::RB_LSB + 2];
  assign o_mem_addr           = ptr_addr;
  assign o_store_data         = opa[15:0];
  assign o_result_excess_flag = state_reg.result_excess_flag;
  assign o_result             = state_reg.result;
  assign o_illegal            = state_reg.illegal;

  chk_flag_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_result_excess_flag |=> o_result_excess_flag)
    else $error("overflow flag cleared");
  chk_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_valid && ovf) |=> o_result_excess_flag)
    else $error("overflow not flagged");
  chk_ptr_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    !o_mem_access |=> $stable(state_reg.data_pointer))
    else $error("pointer moved without access");
  chk_ptr_inc: assert property (@(posedge i_clk) disable iff (!rst_n)
    (o_mem_access && pmode == dapd_pkg::PM_INC && !i_set_step)
      |=> state_reg.data_pointer[$past(pidx)] == $past(state_reg.data_pointer[pidx]) + 16'h0001)
    else $error("increment mode wrong");
  chk_lt_value: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_valid && op_class == dapd_pkg::CL_TWO_OPERAND_CLASS && op == dapd_pkg::D_LT)
      |=> (o_result == dapd_pkg::LT_TRUE || o_result == dapd_pkg::ZERO40))
    else $error("compare result not 0 or 1");
  chk_clear_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_valid && op_class == dapd_pkg::CL_ONE_OPERAND_CLASS && op == dapd_pkg::M_CLR && !access)
      |=> o_result == dapd_pkg::ZERO40)
    else $error("clear not zero");
  chk_exp_upper: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_valid && op_class == dapd_pkg::CL_ONE_OPERAND_CLASS && op == dapd_pkg::M_EXP)
      |=> o_result[39:5] == 35'h0)
    else $error("exponent upper bits set");
  chk_imm_no_mem: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_valid && op_class == dapd_pkg::CL_DYADI) |-> !o_mem_access)
    else $error("immediate form accessed memory");
  cov_mac: cover property (@(posedge i_clk) disable iff (!rst_n)
    i_valid && op_class == dapd_pkg::CL_TRI && access);
  cov_mod: cover property (@(posedge i_clk) disable iff (!rst_n)
    o_mem_access && pmode == dapd_pkg::PM_MOD);
  cov_ovf: cover property (@(posedge i_clk) disable iff (!rst_n)
    !o_result_excess_flag ##1 o_result_excess_flag);
endmodule
`default_nettype wire

// *** rtl/dapd_pkg.sv ***
// package for the arithmetic and pointer datapath: encodings, field layout, limits
// assumes a decoder that presents one 32-bit instruction word per cycle
package dapd_pkg;
  localparam int INSTR_W = 32;
  localparam int REG_W   = 40;
  localparam int HALF_W  = 16;
  localparam int NREG    = 8;
  localparam int NPTR    = 8;
  // instruction fields
  localparam int CLASS_LSB = 28;
  localparam int OP_LSB    = 23;
  localparam int RA_LSB    = 20;
  localparam int RB_LSB    = 17;
  localparam int RD_LSB    = 14;
  localparam int LS_BIT    = 13;
  localparam int PTR_LSB   = 10;
  localparam int MOD_LSB   = 7;
  localparam int IMM_LSB   = 0;
  // operation classes
  localparam logic [3:0] CL_TRI   = 4'h0;
  localparam logic [3:0] CL_TWO_OPERAND_CLASS  = 4'h1;
  localparam logic [3:0] CL_DYADI = 4'h2;
  localparam logic [3:0] CL_ONE_OPERAND_CLASS = 4'h3;
  localparam logic [3:0] CL_LDST  = 4'h4;
  localparam logic [3:0] CL_TRANS = 4'h5;
  localparam logic [3:0] CL_IMM   = 4'h6;
  localparam logic [3:0] CL_BR    = 4'h7;
  localparam logic [3:0] CL_LOOP  = 4'h8;
  localparam logic [3:0] CL_CTL   = 4'h9;
  // trinomial ops
  localparam logic [4:0] T_MADD  = 5'h00;
  localparam logic [4:0] T_MSUB  = 5'h01;
  localparam logic [4:0] T_SUMA  = 5'h02;
  localparam logic [4:0] T_UUMA  = 5'h03;
  localparam logic [4:0] T_SH1MA = 5'h04;
  localparam logic [4:0] T_SH16M = 5'h05;
  // dyadic ops
  localparam logic [4:0] D_MUL = 5'h00;
  localparam logic [4:0] D_ADD = 5'h01;
  localparam logic [4:0] D_SUB = 5'h02;
  localparam logic [4:0] D_SRA = 5'h03;
  localparam logic [4:0] D_SRL = 5'h04;
  localparam logic [4:0] D_SLL = 5'h05;
  localparam logic [4:0] D_AND = 5'h06;
  localparam logic [4:0] D_OR  = 5'h07;
  localparam logic [4:0] D_XOR = 5'h08;
  localparam logic [4:0] D_LT  = 5'h09;
  // monadic ops
  localparam logic [4:0] M_CLR  = 5'h00;
  localparam logic [4:0] M_INC  = 5'h01;
  localparam logic [4:0] M_DEC  = 5'h02;
  localparam logic [4:0] M_ABS  = 5'h03;
  localparam logic [4:0] M_NOT  = 5'h04;
  localparam logic [4:0] M_NEG  = 5'h05;
  localparam logic [4:0] M_CLIP = 5'h06;
  localparam logic [4:0] M_RND  = 5'h07;
  localparam logic [4:0] M_EXP  = 5'h08;
  localparam logic [4:0] M_MOV  = 5'h09;
  // pointer modify modes
  localparam logic [2:0] PM_NONE = 3'h0;
  localparam logic [2:0] PM_INC  = 3'h1;
  localparam logic [2:0] PM_DEC  = 3'h2;
  localparam logic [2:0] PM_IDX  = 3'h3;
  localparam logic [2:0] PM_MOD  = 3'h4;
  localparam logic [2:0] PM_REV  = 3'h5;
  localparam logic [2:0] PM_IMM  = 3'h6;
  // limits and constants
  localparam logic [39:0] SAT_POS   = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_NEG   = 40'hFF80000000;
  localparam logic [39:0] RND_POS   = 40'h007FFF0000;
  localparam logic [39:0] RND_ADD   = 40'h0000008000;
  localparam logic [39:0] RND_MASK  = 40'hFFFFFF0000;
  localparam logic [39:0] LT_TRUE   = 40'h0000000001;
  localparam logic [39:0] ZERO40    = 40'h0000000000;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] SIZE_RESET = 16'hFFFF;
  localparam logic [1:0]  SYNC_RESET = 2'h0;
endpackage

// *** rtl/dapd_ptr_unit.sv ***
// post-access update of one data pointer
// assumes mode, step and size come from the caller in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dapd_ptr_unit #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] i_ptr,
  input  wire logic [W-1:0] i_step,
  input  wire logic [W-1:0] i_size,
  input  wire logic [W-1:0] i_imm,
  input  wire logic [2:0]   i_mode,
  output logic      [W-1:0] o_next,
  output logic      [W-1:0] o_addr
);
  initial if (W < 2 || W > 32) $error("dapd_ptr_unit: width out of range");
  logic [W-1:0] modulus;
  logic [W-1:0] upper;
  logic [W-1:0] low;
  logic [W:0]   low_sum;
  logic [W:0]   low_mod;
  always_comb begin
    // modulus is size+1; upper part is the aligned block above it
    modulus = i_size + W'(1);
    upper   = 'h0;
    low     = i_ptr;
    for (int b = W - 1; b >= 0; b--) begin
      if ((W'(1) << b) > i_size) begin
        upper[b] = i_ptr[b];
        low[b]   = 1'b0;
      end
    end
    low_sum = {1'b0, low} + {1'b0, i_step};
    low_mod = (modulus == 'h0) ? low_sum : low_sum % {1'b0, modulus};
    o_addr  = i_ptr;
    case (i_mode)
      dapd_pkg::PM_NONE: o_next = i_ptr;
      dapd_pkg::PM_INC:  o_next = i_ptr + W'(1);
      dapd_pkg::PM_DEC:  o_next = i_ptr - W'(1);
      dapd_pkg::PM_IDX:  o_next = i_ptr + i_step;
      dapd_pkg::PM_MOD:  o_next = low_mod[W-1:0] + upper;
      dapd_pkg::PM_REV: begin
        o_next = i_ptr + i_step;
        for (int b = 0; b < W; b++) o_addr[b] = i_ptr[W-1-b];
      end
      dapd_pkg::PM_IMM:  o_next = i_ptr + i_imm;
      default:           o_next = i_ptr;
    endcase
  end
endmodule
`default_nettype wire

// *** rtl/dapd_norm_count.sv ***
// count of redundant sign bits in the low 32 bits of an operand
// assumes pure combinational use
`timescale 1ns/1ps
`default_nettype none
module dapd_norm_count (
  input  wire logic [39:0] i_val,
  output logic      [39:0] o_count
);
  logic [4:0] cnt;
  logic       stop;
  always_comb begin
    cnt  = 5'h00;
    stop = 1'b0;
    for (int b = 30; b >= 0; b--) begin
      if (!stop && i_val[b] == i_val[31]) cnt = cnt + 5'h01;
      else stop = 1'b1;
    end
    o_count = {35'h0, cnt};
  end
endmodule
`default_nettype wire

// *** tb/dapd_mem_model.sv ***
// data-memory path model: answers loads in the access cycle
// assumes the datapath drives address and access combinationally
`timescale 1ns/1ps
`default_nettype none
module dapd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_access,
  input  wire logic [15:0] i_addr,
  output logic      [15:0] o_load_data
);
  logic [15:0] last_reg = 16'h0000;
  // idle bus toggles each cycle, never holds stale data
  assign o_load_data = i_access ? (i_addr ^ 16'h5A5A) : ~last_reg;
  always_ff @(posedge i_clk) begin
    last_reg <= o_load_data;
  end
endmodule
`default_nettype wire

// *** tb/dapd_datapath_tb_top.sv ***
// bench for the datapath: drives instructions, checks results and addresses
// assumes the memory model answers each access in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dapd_datapath_tb_top;
  logic        clk = 1'b0, rstn = 1'b0, vld = 1'b0, sst = 1'b0, ssz = 1'b0;
  logic        acc, wr, xf, ill;
  logic [31:0] ins = 32'h0000_0000;
  logic [15:0] ld, addr, sd, sv = 16'h0000;
  logic [2:0]  si = 3'h0;
  logic [39:0] res;
  int          n_mismatch = 0, n_checks = 0;
  dapd_datapath uut (.i_clk(clk), .i_resetn(rstn), .i_valid(vld), .i_instr(ins),
    .i_load_data(ld), .i_set_step(sst), .i_set_size(ssz), .i_set_index(si),
    .i_set_value(sv), .o_mem_access(acc), .o_mem_write(wr), .o_mem_addr(addr),
    .o_store_data(sd), .o_result_excess_flag(xf), .o_result(res), .o_illegal(ill));
  dapd_mem_model mem (.i_clk(clk), .i_access(acc), .i_addr(addr), .o_load_data(ld));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] ri(logic [3:0] c, logic [4:0] o, logic [2:0] a, d,
                                     logic [12:0] im);
    return {c, o, a, 3'h0, d, 1'b0, im};
  endfunction
  function automatic logic [31:0] rr(logic [3:0] c, logic [4:0] o, logic [2:0] a, b, d);
    return {c, o, a, b, d, 14'h0000};
  endfunction
  task automatic ex(logic [31:0] w);
    @(negedge clk);
    vld = 1'b1;
    ins = w;
    @(posedge clk);
    #1;
  endtask
  task automatic mem_op(logic [3:0] c, logic [2:0] m, logic [6:0] im, logic [15:0] ea);
    @(negedge clk);
    vld = 1'b1;
    ins = {c, 5'h00, 3'h0, 3'h0, 3'h0, 1'b1, 3'h1, m, im};
    #1;
    if (c == dapd_pkg::CL_LDST) chk("mem_addr", {24'h0, ea}, {24'h0, addr});
    chk("mem_access", {39'h0, c == dapd_pkg::CL_LDST}, {39'h0, acc});
    @(posedge clk);
    #1;
  endtask
  task automatic setr(logic st, logic [2:0] i, logic [15:0] v);
    @(negedge clk);
    vld = 1'b0;
    sst = st;
    ssz = ~st;
    si = i;
    sv = v;
    @(negedge clk);
    sst = 1'b0;
    ssz = 1'b0;
  endtask
  task automatic t_alu;
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h0, 3'h1, 13'h0064));
    chk("add_imm", 40'h0000000064, res);
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h0, 3'h2, 13'h1FFD));
    chk("add_neg", 40'hFFFFFFFFFD, res);
    ex({dapd_pkg::CL_TWO_OPERAND_CLASS, dapd_pkg::D_LT, 3'h2, 3'h1, 3'h4, 14'h0});
    chk("lt_true", dapd_pkg::LT_TRUE, res);
    ex({dapd_pkg::CL_TWO_OPERAND_CLASS, dapd_pkg::D_LT, 3'h1, 3'h2, 3'h4, 14'h0});
    chk("lt_false", 40'h0000000000, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_NEG, 3'h1, 3'h5, 13'h0000));
    chk("negate", 40'hFFFFFFFF9C, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_CLR, 3'h1, 3'h1, 13'h0000));
    chk("clear", 40'h0000000000, res);
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h0, 3'h6, 13'h0001));
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_SLL, 3'h6, 3'h6, 13'h0027));
    chk("shift_left", 40'h8000000000, res);
    chk("flag_clear", 40'h0, {39'h0, xf});
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_DEC, 3'h6, 3'h6, 13'h0000));
    chk("dec_wrap", 40'h7FFFFFFFFF, res);
    chk("flag_set", 40'h1, {39'h0, xf});
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h0, 3'h7, 13'h0001));
    chk("flag_sticky", 40'h1, {39'h0, xf});
    $display("test alu done");
  endtask
  task automatic t_ptr;
    setr(1'b1, 3'h1, 16'h0003);
    setr(1'b0, 3'h0, 16'h0003);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_IDX, 7'h00, 16'h0000);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_MOD, 7'h00, 16'h0003);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_REV, 7'h00, 16'h4000);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_NONE, 7'h00, 16'h0005);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_IMM, 7'h04, 16'h0005);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_INC, 7'h00, 16'h0009);
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_DEC, 7'h00, 16'h000A);
    mem_op(dapd_pkg::CL_IMM, dapd_pkg::PM_INC, 7'h00, 16'h0000);
    chk("illegal", 40'h1, {39'h0, ill});
    mem_op(dapd_pkg::CL_LDST, dapd_pkg::PM_NONE, 7'h00, 16'h0009);
    $display("test pointer done");
  endtask
  task automatic t_mac;
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h0, 3'h3, 13'h0003));
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_SLL, 3'h3, 3'h3, 13'h0010));
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_ADD, 3'h3, 3'h3, 13'h0005));
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_MADD, 3'h2, 3'h3, 3'h4) | 32'h0000_2000);
    chk("madd", 40'hFFFFFFFFFD, res);
    chk("mac_access", 40'h1, {39'h0, acc});
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_MSUB, 3'h2, 3'h3, 3'h4));
    chk("msub", 40'h0000000000, res);
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_SUMA, 3'h3, 3'h2, 3'h4));
    chk("sign_unsign", 40'h000002FFF7, res);
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_UUMA, 3'h2, 3'h2, 3'h4));
    chk("unsign_unsign", 40'h00FFFD0000, res);
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_SH1MA, 3'h2, 3'h3, 3'h4));
    chk("shift1_mac", 40'h007FFE7FFD, res);
    ex(rr(dapd_pkg::CL_TRI, dapd_pkg::T_SH16M, 3'h2, 3'h3, 3'h4));
    chk("shift16_mac", 40'h0000007FFB, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_ABS, 3'h5, 3'h1, 13'h0000));
    chk("magnitude", 40'h0000000064, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_CLIP, 3'h6, 3'h1, 13'h0000));
    chk("clip_pos", 40'h007FFFFFFF, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_RND, 3'h6, 3'h1, 13'h0000));
    chk("round_pos", 40'h007FFF0000, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_RND, 3'h3, 3'h1, 13'h0000));
    chk("round", 40'h0000030000, res);
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_EXP, 3'h3, 3'h1, 13'h0000));
    chk("norm_count", 40'h000000000D, res);
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_SRA, 3'h2, 3'h1, 13'h0001));
    chk("arith_right", 40'hFFFFFFFFFE, res);
    ex(rr(dapd_pkg::CL_TWO_OPERAND_CLASS, dapd_pkg::D_SRL, 3'h2, 3'h7, 3'h1));
    chk("logic_right", 40'h7FFFFFFFFE, res);
    ex(rr(dapd_pkg::CL_TWO_OPERAND_CLASS, dapd_pkg::D_XOR, 3'h3, 3'h7, 3'h1));
    chk("xor_reg", 40'h0000030004, res);
    ex(ri(dapd_pkg::CL_DYADI, dapd_pkg::D_XOR, 3'h3, 3'h1, 13'h000F));
    chk("xor_imm", 40'h000003000A, res);
    $display("test mac done");
  endtask
  task automatic t_ldst;
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_MOV, 3'h0, 3'h1, 13'h0000));
    chk("load_data", 40'h0000005A53, res);
    @(negedge clk);
    ins = {dapd_pkg::CL_LDST, 5'h00, 3'h3, 3'h4, 3'h0, 1'b1, 3'h1, dapd_pkg::PM_NONE, 7'h00};
    #1;
    chk("store_write", 40'h1, {39'h0, wr});
    chk("store_data", 40'h0000000005, {24'h0, sd});
    chk("store_addr", 40'h0000000009, {24'h0, addr});
    @(posedge clk);
    #1;
    chk("illegal_clear", 40'h0, {39'h0, ill});
    ex(ri(dapd_pkg::CL_ONE_OPERAND_CLASS, dapd_pkg::M_MOV, 3'h0, 3'h1, 13'h0000));
    chk("store_keeps", 40'h0000005A53, res);
    $display("test load store done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    t_alu();
    t_mac();
    t_ptr();
    t_ldst();
    stop_test();
  end
endmodule
`default_nettype wire
